// ==== adc_byte_parallel_host_port.sv ====
// Parallel host port of the sampling converter: byte writes, reads, busy
`timescale 1ns/1ps
module adc_byte_parallel_host_port
(
	input  wire logic                      sys_clk_i,
	input  wire logic                      rst_b_i,
	input  wire host_port_pkg::host_pins_s pins_i,
	input  wire logic [8:0]                data_bus_lines_i,
	output      logic [11:0]               data_bus_lines_o,
	output      logic [11:0]               data_bus_lines_oe_o,
	input  wire logic [11:0]               sampled_code_i,
	output      logic                      hold_o,
	output      logic                      busy_o
);
	import host_port_pkg::*;

	host_pins_s  pins_s;
	host_pins_s  pins_prev_reg;
	conv_state_e state_reg;
	conv_state_e state_next;
	logic [7:0]  count_reg;
	logic [7:0]  count_next;
	logic [13:0] ctrl_reg;
	logic [13:0] test_reg;
	logic [13:0] cal_reg;
	logic [11:0] result_reg;
	logic [7:0]  low_byte_reg;
	logic        low_seen_reg;
	logic [7:0]  din_meta_reg;
	logic [7:0]  din_sync_reg;
	logic [11:0] out_reg;
	logic        cal_req_reg;

	pin_sync u_pin_sync
	(
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.pins_i    (pins_i),
		.pins_o    (pins_s)
	);

	function automatic logic [11:0] code_format(input logic [11:0] code,
		input logic bipolar);
		code_format = bipolar ? {~code[11], code[10:0]} : code;
	endfunction : code_format

	wire selected   = !pins_s.cs_b;
	wire reading    = selected && !pins_s.rd_b;
	wire write_end  = selected && pins_s.wr_b && !pins_prev_reg.wr_b;
	wire trig_fall  = pins_prev_reg.conversion_trigger
		&& !pins_s.conversion_trigger;
	wire trig_rise  = !pins_prev_reg.conversion_trigger
		&& pins_s.conversion_trigger;
	wire mclk_tick  = pins_s.master_clock_input
		&& !pins_prev_reg.master_clock_input;
	wire hi_write   = write_end && pins_s.byte_select;
	wire lo_write   = write_end && !pins_s.byte_select;
	wire commit     = hi_write && low_seen_reg;
	wire [15:0] write_word = {din_sync_reg, low_byte_reg};
	wire [1:0]  write_sel  = {write_word[SEL_HI_POS], write_word[SEL_LO_POS]};
	wire [13:0] payload    = write_word[PAYLOAD_W-1:0];
	wire [1:0]  read_sel   = ctrl_reg[CTRL_RDSEL_HI:CTRL_RDSEL_LO];
	wire [15:0] status_word = {12'h000, cal_req_reg, hold_o, busy_o,
		ctrl_reg[CTRL_BIPOLAR]};
	wire [15:0] read_word =
		(read_sel == RD_TEST)   ? {SEL_TEST, test_reg} :
		(read_sel == RD_CAL)    ? {SEL_CAL, cal_reg} :
		(read_sel == RD_STATUS) ? status_word :
		{4'h0, result_reg};
	wire [11:0] read_sel_data = pins_s.byte_select
		? {4'h0, read_word[WORD_W-1:BYTE_W]}
		: read_word[DATA_W-1:0];
	wire        low_lines_oe  = reading;
	wire        high_lines_oe = reading && !pins_s.byte_select;

	always_comb
	begin
		state_next = state_reg;
		count_next = count_reg;
		unique case (state_reg)
			ST_IDLE:
			begin
				if (cal_req_reg)
				begin
					state_next = ST_CALIBRATE;
					count_next = CAL_MCLK_CYCLES;
				end
				else if (trig_fall)
					state_next = ST_ARMED;
			end
			ST_ARMED:
			begin
				if (trig_rise)
				begin
					state_next = ST_CONVERT;
					count_next = CONV_MCLK_CYCLES;
				end
			end
			ST_CONVERT, ST_CALIBRATE:
			begin
				if (mclk_tick)
				begin
					count_next = count_reg - 8'h01;
					if (count_reg == 8'h01)
						state_next = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_reg     <= ST_IDLE;
			count_reg     <= 8'h00;
			pins_prev_reg <= '{cs_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1,
				byte_select: 1'b0, conversion_trigger: 1'b1,
				master_clock_input: 1'b0};
		end
		else
		begin
			state_reg     <= state_next;
			count_reg     <= count_next;
			pins_prev_reg <= pins_s;
		end
	end

	// Byte assembly; a high byte with no pending low byte is dropped
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			low_byte_reg <= 8'h00;
			low_seen_reg <= 1'b0;
		end
		else if (lo_write)
		begin
			low_byte_reg <= din_sync_reg;
			low_seen_reg <= 1'b1;
		end
		else if (hi_write)
			low_seen_reg <= 1'b0;
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ctrl_reg <= CTRL_RESET;
			test_reg <= TEST_RESET;
			cal_reg  <= CAL_RESET;
		end
		else if (commit)
		begin
			if (write_sel == SEL_CTRL)
				ctrl_reg <= payload;
			if (write_sel == SEL_TEST)
				test_reg <= payload;
			if (write_sel == SEL_CAL)
				cal_reg <= payload;
		end
	end

	// Calibration request: a new request wins over the clear
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			cal_req_reg <= 1'b0;
		else if (commit && write_sel == SEL_CTRL && payload[CTRL_CAL_START])
			cal_req_reg <= 1'b1;
		else if (state_reg == ST_CALIBRATE)
			cal_req_reg <= 1'b0;
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			result_reg <= RESULT_RESET;
		else if (state_reg == ST_CONVERT && state_next == ST_IDLE)
			result_reg <= code_format(sampled_code_i,
				ctrl_reg[CTRL_BIPOLAR]);
	end

	// Output word follows the selection until a read starts, then holds, reloading only when byte_select changes
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			out_reg <= 12'h000;
		else if (!reading || pins_s.byte_select != pins_prev_reg.byte_select)
			out_reg <= read_sel_data;
	end

	// Write data synchronised in step with the strobes
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			din_meta_reg <= 8'h00;
			din_sync_reg <= 8'h00;
		end
		else
		begin
			din_meta_reg <= data_bus_lines_i[7:0];
			din_sync_reg <= din_meta_reg;
		end
	end

	assign data_bus_lines_o    = out_reg;
	assign data_bus_lines_oe_o = {{3{high_lines_oe}}, high_lines_oe,
		{8{low_lines_oe}}};
	assign busy_o = (state_reg != ST_IDLE);
	assign hold_o = (state_reg == ST_CONVERT);
endmodule : adc_byte_parallel_host_port

// ==== host_port_pkg.sv ====
// Shared constants, pin carrier type and the pin synchroniser module
package host_port_pkg;
	localparam int          DATA_W          = 12;
	localparam int          DIN_W           = 9;
	localparam int          BYTE_W          = 8;
	localparam int          WORD_W          = 16;
	localparam int          PAYLOAD_W       = 14;
	localparam int          SEL_HI_POS      = 15;
	localparam int          SEL_LO_POS      = 14;
	localparam logic [1:0]  SEL_NONE        = 2'h0;
	localparam logic [1:0]  SEL_TEST        = 2'h1;
	localparam logic [1:0]  SEL_CAL         = 2'h2;
	localparam logic [1:0]  SEL_CTRL        = 2'h3;
	localparam int          CTRL_BIPOLAR    = 0;
	localparam int          CTRL_CAL_START  = 1;
	localparam int          CTRL_RDSEL_LO   = 6;
	localparam int          CTRL_RDSEL_HI   = 7;
	localparam logic [1:0]  RD_DATA         = 2'h0;
	localparam logic [1:0]  RD_TEST         = 2'h1;
	localparam logic [1:0]  RD_CAL          = 2'h2;
	localparam logic [1:0]  RD_STATUS       = 2'h3;
	localparam logic [13:0] CTRL_RESET      = 14'h0000;
	localparam logic [13:0] TEST_RESET      = 14'h0000;
	localparam logic [13:0] CAL_RESET       = 14'h0000;
	localparam logic [11:0] RESULT_RESET    = 12'h000;
	localparam logic [7:0]  CONV_MCLK_CYCLES = 8'h10;
	localparam logic [7:0]  CAL_MCLK_CYCLES  = 8'hC8;
	localparam int          SYNC_STAGES     = 2;

	typedef struct packed {
		logic cs_b;
		logic rd_b;
		logic wr_b;
		logic byte_select;
		logic conversion_trigger;
		logic master_clock_input;
	} host_pins_s;

	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CONVERT,
		ST_CALIBRATE} conv_state_e;
endpackage : host_port_pkg

`timescale 1ns/1ps
// Two-flop synchroniser for the asynchronous pin group
module pin_sync
(
	input  wire logic                      sys_clk_i,
	input  wire logic                      rst_b_i,
	input  wire host_port_pkg::host_pins_s pins_i,
	output      host_port_pkg::host_pins_s pins_o
);
	import host_port_pkg::*;

	host_pins_s stage1_reg;
	host_pins_s stage2_reg;
	localparam host_pins_s IDLE_PINS = '{cs_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1,
		byte_select: 1'b0, conversion_trigger: 1'b1, master_clock_input: 1'b0};

	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			stage1_reg <= IDLE_PINS;
			stage2_reg <= IDLE_PINS;
		end
		else
		begin
			stage1_reg <= pins_i;
			stage2_reg <= stage1_reg;
		end
	end

	assign pins_o = stage2_reg;
endmodule : pin_sync

// ==== adc_port_sva.sv ====
// Assertions on the host port pins and busy/hold outputs
`timescale 1ns/1ps
module adc_port_sva
(
	input wire logic                      sys_clk_i,
	input wire logic                      rst_b_i,
	input wire host_port_pkg::host_pins_s pins_i,
	input wire logic [11:0]               data_bus_lines_oe_i,
	input wire logic                      hold_i,
	input wire logic                      busy_i
);
	import host_port_pkg::*;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	wire [11:0] oe = data_bus_lines_oe_i;
	a_oe_needs_cs: assert property (
		|oe |-> !$past(pins_i.cs_b, 2))
		else $error("drive without select");
	a_oe_needs_rd: assert property (
		|oe |-> !$past(pins_i.rd_b, 2))
		else $error("drive without read");
	a_upper_lines: assert property (
		|oe[11:8] |-> !$past(pins_i.byte_select, 2))
		else $error("upper lines on in high byte read");
	a_full_word: assert property (
		oe[0] && !$past(pins_i.byte_select, 2) |-> oe == 12'hFFF)
		else $error("partial word drive");
	a_high_byte: assert property (
		oe[0] && $past(pins_i.byte_select, 2) |-> oe == 12'h0FF)
		else $error("high byte lanes wrong");
	a_busy_arm: assert property (
		$fell(pins_i.conversion_trigger) && !busy_i |-> ##[1:4] busy_i)
		else $error("busy not raised");
	a_hold_busy: assert property (hold_i |-> busy_i)
		else $error("hold without busy");
	a_hold_start: assert property (
		$rose(pins_i.conversion_trigger) && busy_i && !hold_i
		|-> ##[2:4] hold_i)
		else $error("hold not started");
	a_conv_time: assert property (
		$rose(hold_i) |-> ##56 busy_i ##[1:16] !busy_i)
		else $error("conversion time wrong");
	c_full: cover property (oe == 12'hFFF);
	c_byte: cover property (oe == 12'h0FF);
	c_done: cover property ($fell(busy_i));
endmodule : adc_port_sva

// ==== host_bus_model.sv ====
// Host bus master driving the port pins and master clock
`timescale 1ns/1ps
module host_bus_model
(
	input  wire logic [11:0]               dq_i,
	input  wire logic [11:0]               oe_i,
	input  wire logic                      sys_clk_i,
	output      host_port_pkg::host_pins_s pins_o,
	output      logic [8:0]                dq_o
);
	import host_port_pkg::*;
	logic [8:0] drv;
	logic       drv_en;
	// Released lines show the inverse of the last value
	assign dq_o = drv_en ? drv : ~drv;
	initial
	begin
		pins_o = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
		drv = 9'h000;
		drv_en = 1'b0;
	end
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask : step
	always
	begin
		step(2);
		pins_o.master_clock_input = ~pins_o.master_clock_input;
	end
	task automatic wr_byte(input logic bs, input logic [7:0] b);
		pins_o.byte_select = bs;
		drv = {1'b0, b};
		drv_en = 1'b1;
		pins_o.cs_b = 1'b0;
		pins_o.wr_b = 1'b0;
		step(4);
		pins_o.wr_b = 1'b1;
		step(4);
		pins_o.cs_b = 1'b1;
		drv_en = 1'b0;
		step(4);
	endtask : wr_byte
	// Low byte first, then high byte
	task automatic wr_word(input logic [15:0] w);
		wr_byte(1'b0, w[7:0]);
		wr_byte(1'b1, w[15:8]);
	endtask : wr_word
	task automatic rd(input logic bs, output logic [11:0] d,
		output logic [11:0] e);
		pins_o.byte_select = bs;
		pins_o.cs_b = 1'b0;
		pins_o.rd_b = 1'b0;
		step(5);
		d = dq_i;
		e = oe_i;
		pins_o.rd_b = 1'b1;
		pins_o.cs_b = 1'b1;
		step(5);
	endtask : rd
	// Write then read strobes with chip select left high
	task automatic unsel(input logic bs, input logic [7:0] b,
		output logic [11:0] e);
		pins_o.byte_select = bs;
		drv = {1'b0, b};
		drv_en = 1'b1;
		pins_o.wr_b = 1'b0;
		step(4);
		pins_o.wr_b = 1'b1;
		pins_o.rd_b = 1'b0;
		step(5);
		e = oe_i;
		pins_o.rd_b = 1'b1;
		drv_en = 1'b0;
		step(5);
	endtask : unsel
	task automatic conv;
		pins_o.conversion_trigger = 1'b0;
		step(4);
		pins_o.conversion_trigger = 1'b1;
		step(4);
	endtask : conv
endmodule : host_bus_model

// ==== adc_byte_parallel_host_port_tb_top.sv ====
// Bench for the host port: reads, byte writes, conversion, calibration
`timescale 1ns/1ps
module adc_byte_parallel_host_port_tb_top;
	import host_port_pkg::*;
	logic       sys_clk;
	logic       rst_b;
	logic [11:0] code;
	logic [11:0] dq_out;
	logic [11:0] oe;
	logic [8:0]  host_d;
	logic       hold;
	logic       busy;
	host_pins_s  pins;
	int          bad_count;
	int          cmp_count;
	wire  [8:0]  dq_in = (oe[8:0] & dq_out[8:0]) | (~oe[8:0] & host_d);
	host_bus_model u_host_bus_model (.dq_i(dq_out), .oe_i(oe),
		.sys_clk_i(sys_clk), .pins_o(pins), .dq_o(host_d));
	adc_byte_parallel_host_port u_adc_byte_parallel_host_port (
		.sys_clk_i(sys_clk), .rst_b_i(rst_b), .pins_i(pins),
		.data_bus_lines_i(dq_in), .data_bus_lines_o(dq_out),
		.data_bus_lines_oe_o(oe), .sampled_code_i(code),
		.hold_o(hold), .busy_o(busy));
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic stop_test;
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd_chk(input logic bs, input logic [11:0] ed,
		input logic [11:0] eo);
		logic [11:0] d;
		logic [11:0] e;
		u_host_bus_model.rd(bs, d, e);
		chk(e, eo);
		chk(d & e, ed);
	endtask : rd_chk
	task automatic wait_idle(input int n);
		for (int i = 0; i < n && busy !== 1'b0; i++)
			@(posedge sys_clk);
		#1;
		if (busy !== 1'b0)
		begin
			bad_count++;
			$display("mismatch at %0t: busy stuck", $time);
			stop_test();
		end
	endtask : wait_idle
	task automatic conv(input logic [11:0] c);
		code = c;
		u_host_bus_model.conv();
		chk({11'h000, busy}, 12'h001);
		wait_idle(150);
	endtask : conv
	task automatic t_reg(input logic [15:0] w, input logic [15:0] ctl,
		input logic [11:0] lo, input logic [11:0] hi);
		u_host_bus_model.wr_word(w);
		u_host_bus_model.wr_word(ctl);
		rd_chk(1'b0, lo, 12'hFFF);
		rd_chk(1'b1, hi, 12'h0FF);
	endtask : t_reg
	task automatic t_unsel;
		logic [11:0] e;
		u_host_bus_model.wr_byte(1'b0, 8'h40);
		u_host_bus_model.unsel(1'b1, 8'hC0, e);
		chk(e, 12'h000);
		rd_chk(1'b0, 12'h001, 12'hFFF);
	endtask : t_unsel
	initial
	begin
		bad_count = 0;
		cmp_count = 0;
		rst_b = 1'b0;
		code = 12'h000;
		repeat (12) @(posedge sys_clk);
		#1;
		rst_b = 1'b1;
		u_host_bus_model.step(4);
		chk(oe, 12'h000);
		rd_chk(1'b0, RESULT_RESET, 12'hFFF);
		conv(12'hA5C);
		rd_chk(1'b0, 12'hA5C, 12'hFFF);
		rd_chk(1'b1, 12'h00A, 12'h0FF);
		u_host_bus_model.wr_byte(1'b0, 8'h01);
		conv(12'h3F0);
		rd_chk(1'b0, 12'h3F0, 12'hFFF);
		u_host_bus_model.wr_word(16'hC001);
		conv(12'h3F0);
		rd_chk(1'b0, 12'hBF0, 12'hFFF);
		t_reg(16'h4123, 16'hC040, 12'h123, 12'h041);
		t_reg(16'h8ABC, 16'hC080, 12'hABC, 12'h08A);
		u_host_bus_model.wr_word(16'hC002);
		u_host_bus_model.step(780);
		chk({11'h000, busy}, 12'h001);
		wait_idle(40);
		t_reg(16'h0000, 16'hC0C1, 12'h001, 12'h000);
		t_unsel();
		stop_test();
	end
endmodule : adc_byte_parallel_host_port_tb_top
bind adc_byte_parallel_host_port adc_port_sva u_adc_port_sva (
	.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .pins_i(pins_i),
	.data_bus_lines_oe_i(data_bus_lines_oe_o), .hold_i(hold_o),
	.busy_i(busy_o));
